// ==== rtl/ssm_pkg.sv ====
// Package of register map, field positions and timing for the socket status block.
package ssm_pkg;

    localparam logic [7:0]  OFS_EVENT   = 8'h00;
    localparam logic [7:0]  OFS_MASK    = 8'h04;
    localparam logic [7:0]  OFS_PRESENT = 8'h08;
    localparam logic [7:0]  OFS_FORCE   = 8'h0C;

    localparam logic [31:0] MASK_RESET    = 32'h0000_0000;
    localparam logic [31:0] PRESENT_RESET = 32'h3000_0000;
    localparam logic [3:0]  SOCK_CAP_RESET = 4'h3;

    localparam int EV_POWER  = 3;
    localparam int EV_DET2   = 2;
    localparam int EV_DET1   = 1;
    localparam int EV_STATUS = 0;

    localparam int PS_SOCK_HI   = 31;
    localparam int PS_SOCK_LO   = 28;
    localparam int PS_VIDEO     = 27;
    localparam int PS_CARD_HI   = 13;
    localparam int PS_CARD_LO   = 10;
    localparam int PS_BADREQ    = 9;
    localparam int PS_LOSS      = 8;
    localparam int PS_NOTCARD   = 7;
    localparam int PS_READY     = 6;
    localparam int PS_CARDBUS   = 5;
    localparam int PS_CARD16    = 4;
    localparam int PS_POWERED   = 3;
    localparam int FE_REIDENT   = 14;

    localparam logic [1:0]  DET_MASK_ON = 2'h3;

    localparam int CLOCK_MHZ     = 50;
    localparam int IDENT_TIME_NS = 1000;
    localparam int IDENT_CYCLES  = (IDENT_TIME_NS * CLOCK_MHZ + 999) / 1000;

    typedef struct packed {
        logic        sel;
        logic        write;
        logic [7:0]  addr;
        logic [31:0] wdata;
    } ssm_bus_req_s;

    typedef enum {ST_EMPTY, ST_IDENT, ST_READY} ssm_ident_e;

endpackage

// ==== rtl/ssm_pin_sync.sv ====
// Three-stage synchroniser for the socket pins with agreement filter.
`timescale 1ns/100ps
module ssm_pin_sync (
    input  wire logic       clock,    // System clock.
    input  wire logic       reset_n,  // Asynchronous reset, active low.
    input  wire logic [3:0] pins_in,  // Raw socket pins.
    output logic      [3:0] pins_out  // Filtered synchronous levels.
);
    logic [3:0] stage1_reg;
    logic [3:0] stage2_reg;
    logic [3:0] stage3_reg;

    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            stage1_reg <= 4'hF;
            stage2_reg <= 4'hF;
            stage3_reg <= 4'hF;
        end
        else
        begin
            stage1_reg <= pins_in;
            stage2_reg <= stage1_reg;
            stage3_reg <= stage2_reg;
        end
    end

    // A level is taken only when the second and third stages agree.
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
            pins_out <= 4'hF;
        else
            for (int i = 0; i < 4; i++)
                if (stage2_reg[i] == stage3_reg[i])
                    pins_out[i] <= stage3_reg[i];
    end
endmodule

// ==== rtl/ssm_socket_status.sv ====
// Socket event, mask, present-state and force-event registers of one socket.
`timescale 1ns/100ps
module ssm_socket_status
    import ssm_pkg::*;
#(
    parameter logic VIDEO_PORT_DEFAULT = 1'b0
) (
    input  wire logic          clock,                   // System clock, 50 MHz.
    input  wire logic          reset_n,                 // Asynchronous reset, active low.
    input  wire ssm_bus_req_s  bus_req,                 // Register request, one cycle.
    output logic               bus_ack,                 // Answer strobe, one cycle.
    output logic [31:0]        bus_rdata,               // Read data, valid with ack.
    input  wire logic          card_detect_pin_one_n,   // First detect pin, low = card.
    input  wire logic          card_detect_pin_two_n,   // Second detect pin, low = card.
    input  wire logic          card_status_change_pin,  // Card status-change pin.
    input  wire logic          card_ready_pin,          // Card ready or interrupt pin.
    input  wire logic [3:0]    card_supply_sense,       // Sensed card supply set Y,X,3V3,5V0.
    input  wire logic          card_sense_cardbus,      // Sensed type, 1 = 32-bit card.
    input  wire logic          card_sense_valid,        // Sensed type is recognisable.
    input  wire logic          socket_power_on,         // Socket supply is on.
    input  wire logic          supply_request_bad,      // Pulse: invalid supply request.
    input  wire logic          card_cycle_pending,      // Cycle open or write data held.
    output logic               socket_change_interrupt  // Status change interrupt.
);

    logic [3:0]  pins_now;
    logic [1:0]  detect_now;
    logic        status_now;
    logic        card_in;
    logic        wr_hit;
    logic        rd_hit;
    logic        force_wr;
    logic        ident_done;
    logic [31:0] present_word;
    logic [3:0]  event_set;
    logic [3:0]  event_enable;

    ssm_ident_e  state_reg;
    ssm_ident_e  state_next;
    logic [15:0] ident_cnt_reg;

    logic [3:0]  mask_reg;
    logic [3:0]  event_reg;
    logic [3:0]  sock_cap_reg;
    logic        video_reg;
    logic [3:0]  card_cap_reg;
    logic        badreq_reg;
    logic        loss_reg;
    logic        notcard_reg;
    logic        cardbus_reg;
    logic        card16_reg;
    logic        powered_reg;
    logic [1:0]  det_shown_reg;
    logic        status_shown_reg;
    logic        powered_prev_reg;
    logic [1:0]  det_prev_reg;
    logic        status_prev_reg;

    function automatic logic is_write(input ssm_bus_req_s req, input logic [7:0] ofs);
        is_write = req.sel && req.write && (req.addr == ofs);
    endfunction

    ssm_pin_sync u_pin_sync (
        .clock    (clock),
        .reset_n  (reset_n),
        .pins_in  ({card_ready_pin, card_status_change_pin,
                    card_detect_pin_two_n, card_detect_pin_one_n}),
        .pins_out (pins_now)
    );

    assign detect_now = pins_now[1:0];
    assign status_now = pins_now[2];
    assign card_in    = (detect_now == 2'b00);
    assign wr_hit     = bus_req.sel && bus_req.write;
    assign rd_hit     = bus_req.sel && !bus_req.write;
    assign force_wr   = is_write(bus_req, OFS_FORCE);
    assign ident_done = (state_reg == ST_IDENT) && (ident_cnt_reg == 16'h0000);

    // Card identification sequence. A forced re-identification restarts it.
    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            ST_EMPTY:
                if (card_in)
                    state_next = ST_IDENT;
            ST_IDENT:
                if (ident_done)
                    state_next = card_in ? ST_READY : ST_EMPTY;
            ST_READY:
                if (!card_in)
                    state_next = ST_EMPTY;
            default:
                state_next = ST_EMPTY;
        endcase
        if (force_wr && bus_req.wdata[FE_REIDENT])
            state_next = ST_IDENT;
    end

    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
            state_reg <= ST_EMPTY;
        else
            state_reg <= state_next;
    end

    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
            ident_cnt_reg <= 16'h0000;
        else if (state_next == ST_IDENT && (state_reg != ST_IDENT || force_wr))
            ident_cnt_reg <= 16'(IDENT_CYCLES - 1);
        else if (state_reg == ST_IDENT && ident_cnt_reg != 16'h0000)
            ident_cnt_reg <= ident_cnt_reg - 16'h0001;
    end

    // Interrupt mask; only the four low bits exist.
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
            mask_reg <= MASK_RESET[3:0];
        else if (is_write(bus_req, OFS_MASK))
            mask_reg <= bus_req.wdata[3:0];
    end

    // Detect bits freeze while the card is being identified. The entry edge is frozen too,
    // otherwise the level that starts identification would already show through.
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
            det_shown_reg <= 2'b11;
        else if (state_reg != ST_IDENT && state_next != ST_IDENT)
            det_shown_reg <= detect_now;
    end

    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            status_shown_reg <= 1'b1;
            powered_reg      <= 1'b0;
        end
        else
        begin
            status_shown_reg <= status_now;
            powered_reg      <= socket_power_on;
        end
    end

    // Socket supply ability and video capability, overridable by force writes.
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            sock_cap_reg <= SOCK_CAP_RESET;
            video_reg    <= VIDEO_PORT_DEFAULT;
        end
        else if (force_wr)
        begin
            sock_cap_reg <= bus_req.wdata[PS_SOCK_HI:PS_SOCK_LO];
            video_reg    <= bus_req.wdata[PS_VIDEO];
        end
    end

    // Card supply and type are taken at the end of identification of a valid card; force writes also set the card supply.
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            card_cap_reg <= 4'h0;
            cardbus_reg  <= 1'b0;
            card16_reg   <= 1'b0;
        end
        else if (force_wr)
            card_cap_reg <= bus_req.wdata[PS_CARD_HI:PS_CARD_LO];
        else if (ident_done && card_in && card_sense_valid)
        begin
            card_cap_reg <= card_supply_sense;
            cardbus_reg  <= card_sense_cardbus;
            card16_reg   <= !card_sense_cardbus;
        end
    end

    // An unrecognisable card keeps its flag until a valid card is identified.
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
            notcard_reg <= 1'b0;
        else if (force_wr)
            notcard_reg <= bus_req.wdata[PS_NOTCARD];
        else if (ident_done && card_in)
            notcard_reg <= !card_sense_valid;
    end

    // Invalid supply request stays set until a fresh card is handled.
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
            badreq_reg <= 1'b0;
        else if (supply_request_bad)
            badreq_reg <= 1'b1;
        else if (force_wr)
            badreq_reg <= bus_req.wdata[PS_BADREQ];
        else if (ident_done)
            badreq_reg <= 1'b0;
    end

    // Removal with an open cycle may have lost data.
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
            loss_reg <= 1'b0;
        else if (state_reg == ST_READY && !card_in && card_cycle_pending)
            loss_reg <= 1'b1;
        else if (force_wr)
            loss_reg <= bus_req.wdata[PS_LOSS];
        else if (ident_done)
            loss_reg <= 1'b0;
    end

    always_comb
    begin
        present_word                        = 32'h0000_0000;
        present_word[PS_SOCK_HI:PS_SOCK_LO] = sock_cap_reg;
        present_word[PS_VIDEO]              = video_reg;
        present_word[PS_CARD_HI:PS_CARD_LO] = card_cap_reg;
        present_word[PS_BADREQ]             = badreq_reg;
        present_word[PS_LOSS]               = loss_reg;
        present_word[PS_NOTCARD]            = notcard_reg;
        present_word[PS_READY]              = pins_now[3];
        present_word[PS_CARDBUS]            = cardbus_reg;
        present_word[PS_CARD16]             = card16_reg;
        present_word[PS_POWERED]            = powered_reg;
        present_word[EV_DET2]               = det_shown_reg[1];
        present_word[EV_DET1]               = det_shown_reg[0];
        present_word[EV_STATUS]             = status_shown_reg;
    end

    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            powered_prev_reg <= 1'b0;
            det_prev_reg     <= 2'b11;
            status_prev_reg  <= 1'b1;
        end
        else
        begin
            powered_prev_reg <= powered_reg;
            det_prev_reg     <= det_shown_reg;
            status_prev_reg  <= status_shown_reg;
        end
    end

    // Change detection on the shown bits; force writes add their own events.
    always_comb
    begin
        event_set[EV_POWER] = powered_reg != powered_prev_reg;
        event_set[EV_DET2]  = det_shown_reg[1] != det_prev_reg[1];
        event_set[EV_DET1]  = det_shown_reg[0] != det_prev_reg[0];
        if (cardbus_reg)
            event_set[EV_STATUS] = status_shown_reg && !status_prev_reg;
        else
            event_set[EV_STATUS] = status_shown_reg != status_prev_reg;
        if (force_wr)
            event_set = event_set | bus_req.wdata[3:0];
    end

    // Hardware set wins over a software clear in the same cycle.
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
            event_reg <= 4'h0;
        else if (is_write(bus_req, OFS_EVENT))
            event_reg <= (event_reg & ~bus_req.wdata[3:0]) | event_set;
        else
            event_reg <= event_reg | event_set;
    end

    // Only the mask value 11 enables detect events; 01 and 10 block them.
    always_comb
    begin
        event_enable[EV_POWER]  = mask_reg[EV_POWER];
        event_enable[EV_DET2]   = mask_reg[2:1] == DET_MASK_ON;
        event_enable[EV_DET1]   = mask_reg[2:1] == DET_MASK_ON;
        event_enable[EV_STATUS] = mask_reg[EV_STATUS];
    end

    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
            socket_change_interrupt <= 1'b0;
        else
            socket_change_interrupt <= |(event_reg & event_enable);
    end

    // Register reads answer one cycle after the request; writes ack too.
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            bus_ack   <= 1'b0;
            bus_rdata <= 32'h0000_0000;
        end
        else
        begin
            bus_ack   <= bus_req.sel;
            bus_rdata <= 32'h0000_0000;
            if (rd_hit)
            begin
                case (bus_req.addr)
                    OFS_EVENT:   bus_rdata <= {28'h0000000, event_reg};
                    OFS_MASK:    bus_rdata <= {28'h0000000, mask_reg};
                    OFS_PRESENT: bus_rdata <= present_word;
                    default:     bus_rdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // Writes to the present-state offset have no effect.
    logic unused_wr;
    assign unused_wr = wr_hit && (bus_req.addr == OFS_PRESENT);

endmodule

// ==== verif/ssm_card_model.sv ====
// Behavioural card that drives the socket pins of the status block.
`timescale 1ns/100ps
module ssm_card_model (
    input  wire logic       plug,    // Card sits in the socket.
    input  wire logic       sts,     // Status-change level of the card.
    input  wire logic [3:0] caps,    // Supplies the card takes.
    input  wire logic       cb,      // Card is a 32-bit card.
    output logic            det_n,   // Both detect pins, low with a card.
    output logic            sts_pin, // Status-change pin.
    output logic            ready,   // Ready pin.
    output logic [3:0]      supply,  // Sensed supply set.
    output logic            is_cb,   // Sensed card type.
    output logic            valid    // Card is recognisable.
);
    // Detect pins are pulled up; status, supply and type lines float with no card, so they show the inverse.
    assign det_n   = ~plug;
    assign sts_pin = plug ? sts : ~sts;
    assign ready   = plug;
    assign supply  = plug ? caps : ~caps;
    assign is_cb   = plug ? cb : ~cb;
    assign valid   = plug;
endmodule

// ==== verif/ssm_socket_status_assertions.sv ====
// Checker of the register port and interrupt of the socket status block.
`timescale 1ns/100ps
module ssm_socket_status_assertions
    import ssm_pkg::*;
(
    input wire logic         clock,                  // System clock.
    input wire logic         reset_n,                // Asynchronous reset, active low.
    input wire ssm_bus_req_s bus_req,                // Register request.
    input wire logic         bus_ack,                // Answer strobe.
    input wire logic [31:0]  bus_rdata,              // Read data.
    input wire logic         socket_change_interrupt // Status change interrupt.
);
    default clocking @(posedge clock); endclocking
    default disable iff (!reset_n);

    logic       was_rd;
    logic       was_wr;
    logic [7:0] was_a;
    logic [3:0] msk;
    logic       forced;
    logic       blk;

    // Shadow of the mask, so interrupt checks need no view of the bodies.
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            was_rd <= 1'b0;
            was_wr <= 1'b0;
            was_a  <= 8'h00;
            msk    <= 4'h0;
            forced <= 1'b0;
        end
        else
        begin
            was_rd <= bus_req.sel & ~bus_req.write;
            was_wr <= bus_req.sel & bus_req.write;
            was_a  <= bus_req.addr;
            if (bus_req.sel && bus_req.write && bus_req.addr == OFS_MASK)
                msk <= bus_req.wdata[3:0];
            if (bus_req.sel && bus_req.write && bus_req.addr == OFS_FORCE)
                forced <= 1'b1;
        end
    end

    assign blk = !msk[3] && !msk[0] && msk[2:1] != DET_MASK_ON;

    sequence s_rd_mask;
        bus_ack && was_rd && was_a == OFS_MASK;
    endsequence
    sequence s_rd_state;
        bus_ack && was_rd && was_a == OFS_PRESENT;
    endsequence

    AST_ACK_NEXT: assert property (bus_req.sel |=> bus_ack)
        else $error("no answer one cycle after a request");
    AST_ACK_CAUSE: assert property (bus_ack |-> $past(bus_req.sel))
        else $error("answer without a request");
    AST_WR_NODATA: assert property (bus_ack && was_wr |-> bus_rdata == 32'h0)
        else $error("read data on a write answer");
    AST_MASK_RSVD: assert property (s_rd_mask |-> bus_rdata == {28'h0, msk})
        else $error("mask read differs from written value");
    AST_PS_RSVD: assert property (s_rd_state |-> bus_rdata[26:14] == 13'h0)
        else $error("reserved state bits not zero");
    AST_SOCK_SUPPLY: assert property (s_rd_state ##0 !forced |-> bus_rdata[31:28] == 4'h3)
        else $error("socket supply bits wrong");
    AST_IRQ_BLOCKED: assert property (blk && $past(blk) |-> !socket_change_interrupt)
        else $error("interrupt while every source is masked");
    AST_IRQ_CAUSE: assert property ($rose(socket_change_interrupt) |-> msk != 0 || $past(msk) != 0)
        else $error("interrupt rose with mask clear");
endmodule

bind ssm_socket_status ssm_socket_status_assertions u_chk (
    .clock                  (clock),
    .reset_n                (reset_n),
    .bus_req                (bus_req),
    .bus_ack                (bus_ack),
    .bus_rdata              (bus_rdata),
    .socket_change_interrupt(socket_change_interrupt)
);

// ==== verif/ssm_socket_status_tb_top.sv ====
// Register-level testbench of the socket status block with a card model.
`timescale 1ns/100ps
module ssm_socket_status_tb_top;
    import ssm_pkg::*;

    logic         clock;
    logic         reset_n;
    ssm_bus_req_s req;
    logic         bus_ack;
    logic [31:0]  bus_rdata;
    logic         irq;
    logic         plug;
    logic         sts;
    logic [3:0]   caps;
    logic         power;
    logic         bad;
    logic         pend;
    logic         det_n;
    logic         sts_pin;
    logic         ready;
    logic [3:0]   supply;
    logic         is_cb;
    logic         valid;
    int           num_errors;
    int           check_count;

    ssm_card_model card (.plug(plug), .sts(sts), .caps(caps), .cb(1'b1), .det_n(det_n),
        .sts_pin(sts_pin), .ready(ready), .supply(supply), .is_cb(is_cb), .valid(valid));

    ssm_socket_status #(.VIDEO_PORT_DEFAULT(1'b1)) dut (
        .clock(clock), .reset_n(reset_n), .bus_req(req), .bus_ack(bus_ack),
        .bus_rdata(bus_rdata), .card_detect_pin_one_n(det_n), .card_detect_pin_two_n(det_n),
        .card_status_change_pin(sts_pin), .card_ready_pin(ready), .card_supply_sense(supply),
        .card_sense_cardbus(is_cb), .card_sense_valid(valid), .socket_power_on(power),
        .supply_request_bad(bad), .card_cycle_pending(pend), .socket_change_interrupt(irq));

    initial
    begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end

    task automatic finish_test;
        $display("errors %0d checks %0d", num_errors, check_count);
        if (num_errors == 0 && check_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            num_errors++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // Entered and left one step after an edge, so no signal moves twice in a time step.
    task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        req = '{1'b1, w, a, d};
        cyc(1);
        req.sel = 1'b0;
        q = bus_rdata;
        chk({31'h0, bus_ack}, 32'h1);
        cyc(1);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        acc(1'b1, a, d, q);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        logic [31:0] q;
        acc(1'b0, a, 32'h0, q);
        chk(q & m, e);
    endtask

    task automatic wirq(input logic e);
        int n;
        n = 0;
        while (irq !== e && n < 20)
        begin
            cyc(1);
            n++;
        end
        chk({31'h0, irq}, {31'h0, e});
    endtask

    initial
    begin
        repeat (5000) @(posedge clock);
        num_errors++;
        finish_test();
    end

    initial
    begin
        reset_n = 1'b0;
        req = '{1'b0, 1'b0, 8'h00, 32'h0};
        {plug, sts, caps, power, bad, pend} = 9'h000;
        num_errors = 0;
        check_count = 0;
        cyc(10);
        reset_n = 1'b1;
        rd(OFS_MASK, 32'hFFFFFFFF, MASK_RESET);
        rd(OFS_PRESENT, 32'hFFFFFF06, 32'h38000006);
        wr(OFS_MASK, 32'hFFFFFFFF);
        rd(OFS_MASK, 32'hFFFFFFFF, 32'h0000000F);
        wr(OFS_PRESENT, 32'h0);
        rd(OFS_PRESENT, 32'hFFFF0000, 32'h38000000);
        wr(OFS_MASK, 32'h0);
        wr(OFS_EVENT, 32'hF);
        sts = 1'b1;
        cyc(10);
        chk({31'h0, irq}, 32'h0);
        rd(OFS_EVENT, 32'hF, 32'h1);
        wr(OFS_MASK, 32'h1);
        wirq(1'b1);
        wr(OFS_EVENT, 32'h1);
        wirq(1'b0);
        rd(OFS_EVENT, 32'hF, 32'h0);
        wr(OFS_MASK, 32'h2);
        sts = 1'b0;
        caps = 4'h3;
        plug = 1'b1;
        cyc(20);
        rd(OFS_PRESENT, 32'h6, 32'h6);
        cyc(60);
        chk({31'h0, irq}, 32'h0);
        rd(OFS_EVENT, 32'h6, 32'h6);
        rd(OFS_PRESENT, 32'h3C06, 32'h0C00);
        wr(OFS_MASK, 32'h6);
        wirq(1'b1);
        wr(OFS_EVENT, 32'hF);
        wr(OFS_MASK, 32'h0);
        caps = 4'hC;
        cyc(10);
        rd(OFS_PRESENT, 32'h3C00, 32'h0C00);
        sts = 1'b1;
        cyc(10);
        rd(OFS_EVENT, 32'h1, 32'h1);
        wr(OFS_EVENT, 32'hF);
        sts = 1'b0;
        cyc(10);
        rd(OFS_EVENT, 32'h1, 32'h0);
        wr(OFS_MASK, 32'h8);
        power = 1'b1;
        wirq(1'b1);
        rd(OFS_PRESENT, 32'h8, 32'h8);
        wr(OFS_MASK, 32'h0);
        bad = 1'b1;
        cyc(1);
        bad = 1'b0;
        cyc(3);
        rd(OFS_PRESENT, 32'h200, 32'h200);
        pend = 1'b1;
        plug = 1'b0;
        cyc(10);
        rd(OFS_PRESENT, 32'h100, 32'h100);
        wr(OFS_FORCE, 32'h80000000);
        rd(OFS_PRESENT, 32'hF0000000, 32'h80000000);
        finish_test();
    end
endmodule
